// ---- shared/csb_pkg.sv ----
// Constants shared by both ends of the serial register link
// Behaviour
// - Start, address, write bit, slave acks match
// - Command 100xxxxx, low five bits index
// - Write: data byte, slave ack, stop
// - Read: restart, address read, slave data, master ack
// - Override set lets software write select bits
// - Override clear: select bits show straps, read-only
// - Select code from bits 6,5,4,1; straps at reset
// - Register 0 bit 0 shows interface strap
// - Register 1 bit 7 spread profile, reset 0
// - Register 1 bit 6 spread enable, reset 1
// - Register 1 bits 5:4 bandwidth, reset 11
// - Bit 3 chipset pair run, else low
// - Bit 2 main pair run, else off
// - Open-drain mode ignores register 1 bit 1
// - Differential, bit1 0: power-down parks true high
// - Differential, bit1 1: power-down floats pair
// - Register 1 bit 0 shows multiplier strap
// - Slave address byte is 11010010
// - Bytes shift most significant bit first
// - Registers take defaults at power-up
package csb_pkg;
   localparam logic [6:0] slave_addr = 7'h69;
   localparam logic [2:0] cmd_byte_op = 3'h4;
   localparam logic [4:0] off_freq = 5'h00;
   localparam logic [4:0] off_cpu = 5'h01;
   localparam int bit_freq2 = 6;
   localparam int bit_freq1 = 5;
   localparam int bit_freq0 = 4;
   localparam int bit_sw_enable = 3;
   localparam int bit_freq3 = 1;
   localparam int bit_cpu_strap = 0;
   localparam int bit_spread_mode = 7;
   localparam int bit_spread_enable = 6;
   localparam int bit_chipset_run = 3;
   localparam int bit_cpu_run = 2;
   localparam int bit_stop_mode = 1;
   localparam logic [7:0] reset_cpu_reg = 8'h7c;
   localparam int half_period = 20;
   localparam logic [7:0] half_count = 8'h14;
   localparam logic [7:0] quarter_count = 8'h0a;
   localparam logic [3:0] bits_per_byte = 4'h8;
endpackage

// ---- shared/csb_link_if.sv ----
// Two-wire link between host controller and clock chip
`timescale 1ns/1ps
interface csb_link_if;
   logic scl_o;
   logic scl_oe;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic scl;
   logic sda;
   // Open-drain resolution with pull-ups
   assign scl = scl_oe ? scl_o : 1'b1;
   assign sda = (sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o) ? 1'b0 : 1'b1;
   modport host (output scl_o, scl_oe, sda_host_o, sda_host_oe, input scl, sda);
   modport device (output sda_dev_o, sda_dev_oe, input scl, sda);
endinterface

// ---- rtl/csb_sync.sv ----
// Two-stage synchroniser for the link pins
`timescale 1ns/1ps
module csb_sync #(parameter int width = 2) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);
   logic [width-1:0] stage1;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         stage1 <= '1;
         sync_out <= '1;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// ---- rtl/csb_device.sv ----
// Clock chip end: serial slave and the first two control registers
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module csb_device (
   input wire logic clk_sys,
   input wire logic sys_rst,
   csb_link_if.device link,
   input wire logic [3:0] freq_select_strap,
   input wire logic cpu_interface_strap,
   input wire logic current_multiplier_strap,
   input wire logic power_down_n,
   output logic [3:0] freq_select,
   output logic spread_center,
   output logic spread_enable,
   output logic [1:0] spread_bandwidth,
   output logic chipset_clock_run,
   output logic cpu_clock_run,
   output logic cpu_park_true_high,
   output logic cpu_float,
   output logic [7:0] freq_reg_view,
   output logic [7:0] cpu_reg_view
);
   typedef enum logic [6:0] {
      st_idle = 7'h01,
      st_addr = 7'h02,
      st_cmd = 7'h04,
      st_wdata = 7'h08,
      st_rdata = 7'h10,
      st_ack = 7'h20,
      st_mack = 7'h40
   } csb_dev_state_type;
   typedef struct packed {
      csb_dev_state_type state;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic [4:0] index;
      logic have_cmd;
      logic is_read;
      logic ack_ok;
      logic scl_d;
      logic sda_d;
      logic sda_o;
      logic sda_oe;
      logic sw_enable;
      logic [3:0] freq;
      logic cpu_mode;
      logic mult;
      logic [7:0] cpu_reg;
      logic pd_s1;
      logic pd_s2;
      logic park_hi;
      logic float_out;
   } csb_dev_reg_type;
   csb_dev_reg_type r, next_r;
   logic [1:0] pins;
   logic scl_s, sda_s;
   csb_sync #(.width(2)) pin_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .async_in({link.scl, link.sda}),
      .sync_out(pins)
   );
   assign scl_s = pins[1];
   assign sda_s = pins[0];
   logic [5:0] straps;
   // Strap pins are asynchronous too; they settle three cycles after reset
   csb_sync #(.width(6)) strap_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .async_in({freq_select_strap, cpu_interface_strap, current_multiplier_strap}),
      .sync_out(straps)
   );
   function automatic logic [7:0] read_reg(input csb_dev_reg_type s, input logic [4:0] idx);
      logic [7:0] v;
      v = 8'h00;
      if (idx == csb_pkg::off_freq) begin
         // Reserved bits stay zero
         v[csb_pkg::bit_freq2] = s.freq[2];
         v[csb_pkg::bit_freq1] = s.freq[1];
         v[csb_pkg::bit_freq0] = s.freq[0];
         v[csb_pkg::bit_freq3] = s.freq[3];
         v[csb_pkg::bit_sw_enable] = s.sw_enable;
         v[csb_pkg::bit_cpu_strap] = s.cpu_mode;
      end else if (idx == csb_pkg::off_cpu) begin
         v = {s.cpu_reg[7:1], s.mult};
      end
      return v;
   endfunction
   always_comb begin
      logic rise, fall, start, stop;
      logic [7:0] byte_in;
      rise = 1'b0;
      fall = 1'b0;
      start = 1'b0;
      stop = 1'b0;
      byte_in = 8'h00;
      next_r = r;
      next_r.scl_d = scl_s;
      next_r.sda_d = sda_s;
      next_r.pd_s1 = power_down_n;
      next_r.pd_s2 = r.pd_s1;
      rise = scl_s && !r.scl_d;
      fall = !scl_s && r.scl_d;
      start = scl_s && r.scl_d && r.sda_d && !sda_s;
      stop = scl_s && r.scl_d && !r.sda_d && sda_s;
      byte_in = {r.shift[6:0], sda_s};
      // Straps followed from reset on
      next_r.cpu_mode = straps[1];
      next_r.mult = straps[0];
      if (!r.sw_enable) begin
         next_r.freq = straps[5:2];
      end
      if (start) begin
         // Repeated start keeps the index
         next_r.state = st_addr;
         next_r.cnt = 4'h0;
         next_r.sda_oe = 1'b0;
      end else if (stop) begin
         next_r.state = st_idle;
         next_r.have_cmd = 1'b0;
         next_r.sda_oe = 1'b0;
      end else begin
         case (r.state)
            st_idle: begin
               next_r.sda_oe = 1'b0;
            end
            st_addr, st_cmd, st_wdata: begin
               if (rise) begin
                  next_r.shift = byte_in;
                  next_r.cnt = r.cnt + 4'h1;
               end
               if (fall && r.cnt == csb_pkg::bits_per_byte) begin
                  next_r.ack_ok = 1'b0;
                  if (r.state == st_addr) begin
                     next_r.ack_ok = r.shift[7:1] == csb_pkg::slave_addr
                                     && (r.shift[0] == 1'b0 || r.have_cmd);
                     next_r.is_read = r.shift[0];
                  end else if (r.state == st_cmd) begin
                     next_r.ack_ok = r.shift[7:5] == csb_pkg::cmd_byte_op;
                     next_r.index = r.shift[4:0];
                     next_r.have_cmd = r.shift[7:5] == csb_pkg::cmd_byte_op;
                  end else begin
                     next_r.ack_ok = 1'b1;
                     if (r.index == csb_pkg::off_freq) begin
                        next_r.sw_enable = r.shift[csb_pkg::bit_sw_enable];
                        if (r.sw_enable) begin
                           next_r.freq = {r.shift[csb_pkg::bit_freq3],
                                          r.shift[csb_pkg::bit_freq2],
                                          r.shift[csb_pkg::bit_freq1],
                                          r.shift[csb_pkg::bit_freq0]};
                        end
                     end else if (r.index == csb_pkg::off_cpu) begin
                        next_r.cpu_reg = {r.shift[7:1], 1'b0};
                     end
                  end
                  next_r.sda_o = 1'b0;
                  // Foreign address or non-byte command is left unacknowledged
                  next_r.sda_oe = next_r.ack_ok;
                  next_r.state = st_ack;
               end
            end
            st_ack: begin
               if (fall) begin
                  next_r.cnt = 4'h0;
                  next_r.sda_oe = 1'b0;
                  if (!r.ack_ok) begin
                     next_r.state = st_idle;
                  end else if (r.is_read && r.have_cmd) begin
                     next_r.shift = read_reg(r, r.index);
                     next_r.sda_o = next_r.shift[7];
                     next_r.sda_oe = 1'b1;
                     next_r.state = st_rdata;
                  end else begin
                     next_r.state = r.have_cmd ? st_wdata : st_cmd;
                  end
               end
            end
            st_rdata: begin
               if (fall) begin
                  next_r.cnt = r.cnt + 4'h1;
                  next_r.shift = {r.shift[6:0], 1'b0};
                  next_r.sda_o = r.shift[6];
                  if (r.cnt == 4'h7) begin
                     next_r.sda_oe = 1'b0; // Release for master ack
                     next_r.state = st_mack;
                  end
               end
            end
            st_mack: begin
               if (rise) begin
                  next_r.state = st_idle;
               end
            end
            default: begin
               next_r.state = st_idle;
            end
         endcase
      end
      // Pair control
      next_r.park_hi = !r.cpu_mode && !r.pd_s2 && !r.cpu_reg[csb_pkg::bit_stop_mode];
      next_r.float_out = !r.cpu_mode && !r.pd_s2 && r.cpu_reg[csb_pkg::bit_stop_mode];
   end
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '0;
         r.state <= st_idle;
         r.scl_d <= 1'b1;
         r.sda_d <= 1'b1;
         r.sda_o <= 1'b1;
         r.cpu_reg <= csb_pkg::reset_cpu_reg;
         r.pd_s1 <= 1'b1;
         r.pd_s2 <= 1'b1;
      end else begin
         r <= next_r;
      end
   end
   assign link.sda_dev_o = r.sda_o;
   assign link.sda_dev_oe = r.sda_oe;
   assign freq_select = r.freq;
   assign spread_center = r.cpu_reg[csb_pkg::bit_spread_mode];
   assign spread_enable = r.cpu_reg[csb_pkg::bit_spread_enable];
   assign spread_bandwidth = r.cpu_reg[5:4];
   assign chipset_clock_run = r.cpu_reg[csb_pkg::bit_chipset_run];
   assign cpu_clock_run = r.cpu_reg[csb_pkg::bit_cpu_run];
   assign cpu_park_true_high = r.park_hi;
   assign cpu_float = r.float_out;
   assign freq_reg_view = read_reg(r, csb_pkg::off_freq);
   assign cpu_reg_view = read_reg(r, csb_pkg::off_cpu);
endmodule

// ---- rtl/csb_host.sv ----
// Host controller end: byte write and byte read over the two-wire link
`timescale 1ns/1ps
module csb_host (
   input wire logic clk_sys,
   input wire logic sys_rst,
   csb_link_if.host link,
   input wire logic [1:0] cmd_addr,
   input wire logic [15:0] cmd_wdata,
   input wire logic cmd_write,
   input wire logic cmd_read,
   output logic [15:0] cmd_rdata
);
   // Register 0: [4:0] index, [5] read, [6] go; reads show busy, nack, data
   typedef enum logic [7:0] {
      hs_idle = 8'h01,
      hs_start = 8'h02,
      hs_bit = 8'h04,
      hs_ack = 8'h08,
      hs_rstart = 8'h10,
      hs_stop = 8'h20,
      hs_done = 8'h40,
      hs_rdbit = 8'h80
   } csb_host_state_type;
   typedef struct packed {
      csb_host_state_type state;
      logic [7:0] div;
      logic [1:0] phase;
      logic [3:0] cnt;
      logic [1:0] byte_no;
      logic [7:0] shift;
      logic [4:0] index;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic is_read;
      logic busy;
      logic nack;
      logic scl_o;
      logic sda_o;
      logic [15:0] rd;
   } csb_host_reg_type;
   csb_host_reg_type r, next_r;
   logic [1:0] pins;
   csb_sync #(.width(2)) pin_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .async_in({link.scl, link.sda}),
      .sync_out(pins)
   );
   always_comb begin
      logic tick;
      tick = 1'b0;
      next_r = r;
      next_r.rd = 16'h0000;
      if (cmd_read) begin
         next_r.rd = cmd_addr == 2'h0 ? {6'h00, r.busy, r.nack, r.rdata} : {8'h00, r.wdata};
      end
      next_r.div = r.div + 8'h01;
      if (r.div == csb_pkg::quarter_count - 8'h01) begin
         next_r.div = 8'h00;
         tick = 1'b1;
      end
      if (cmd_write && !r.busy) begin
         if (cmd_addr == 2'h1) begin
            next_r.wdata = cmd_wdata[7:0];
         end else if (cmd_addr == 2'h0 && cmd_wdata[6]) begin
            next_r.index = cmd_wdata[4:0];
            next_r.is_read = cmd_wdata[5];
            next_r.busy = 1'b1;
            next_r.nack = 1'b0;
            next_r.state = hs_start;
            next_r.phase = 2'h0;
         end
      end
      if (tick) begin
         next_r.phase = r.phase + 2'h1;
         case (r.state)
            hs_idle: begin
               next_r.phase = 2'h0;
            end
            hs_start, hs_rstart: begin
               // SDA falls while SCL high
               if (r.phase == 2'h0) begin
                  next_r.sda_o = 1'b1;
                  next_r.scl_o = 1'b1;
               end
               if (r.phase == 2'h1) next_r.sda_o = 1'b0;
               if (r.phase == 2'h3) begin
                  next_r.scl_o = 1'b0;
                  next_r.shift = {csb_pkg::slave_addr, r.state == hs_rstart};
                  next_r.byte_no = r.state == hs_rstart ? 2'h3 : 2'h0;
                  next_r.cnt = 4'h0;
                  next_r.state = hs_bit;
               end
            end
            hs_bit: begin
               if (r.phase == 2'h0) next_r.sda_o = r.shift[7];
               if (r.phase == 2'h1) next_r.scl_o = 1'b1;
               if (r.phase == 2'h3) begin
                  next_r.scl_o = 1'b0;
                  next_r.shift = {r.shift[6:0], 1'b0};
                  next_r.cnt = r.cnt + 4'h1;
                  if (r.cnt == 4'h7) next_r.state = hs_ack;
               end
            end
            hs_ack: begin
               // Host pulls the line itself for the ack after read data
               if (r.phase == 2'h0) next_r.sda_o = !(r.is_read && r.byte_no == 2'h2);
               if (r.phase == 2'h1) next_r.scl_o = 1'b1;
               if (r.phase == 2'h2 && pins[0]) next_r.nack = 1'b1;
               if (r.phase == 2'h3) begin
                  next_r.scl_o = 1'b0;
                  next_r.cnt = 4'h0;
                  next_r.byte_no = r.byte_no + 2'h1;
                  if (r.nack || pins[0]) begin
                     next_r.state = hs_stop;
                  end else if (r.byte_no == 2'h0) begin
                     next_r.shift = {csb_pkg::cmd_byte_op, r.index};
                     next_r.state = hs_bit;
                  end else if (r.byte_no == 2'h1 && r.is_read) begin
                     next_r.state = hs_rstart;
                  end else if (r.byte_no == 2'h1) begin
                     next_r.shift = r.wdata;
                     next_r.state = hs_bit;
                  end else if (r.byte_no == 2'h3) begin
                     next_r.state = hs_rdbit;
                  end else begin
                     next_r.state = hs_stop;
                  end
               end
            end
            hs_rdbit: begin
               if (r.phase == 2'h0) next_r.sda_o = 1'b1;
               if (r.phase == 2'h1) next_r.scl_o = 1'b1;
               if (r.phase == 2'h2) next_r.shift = {r.shift[6:0], pins[0]};
               if (r.phase == 2'h3) begin
                  next_r.scl_o = 1'b0;
                  next_r.cnt = r.cnt + 4'h1;
                  if (r.cnt == 4'h7) begin
                     // Master ack slot, then stop
                     next_r.rdata = r.shift;
                     next_r.byte_no = 2'h2;
                     next_r.state = hs_ack;
                  end
               end
            end
            hs_stop: begin
               if (r.phase == 2'h0) next_r.sda_o = 1'b0;
               if (r.phase == 2'h1) next_r.scl_o = 1'b1;
               if (r.phase == 2'h2) next_r.sda_o = 1'b1;
               if (r.phase == 2'h3) next_r.state = hs_done;
            end
            hs_done: begin
               next_r.busy = 1'b0;
               next_r.state = hs_idle;
            end
            default: begin
               next_r.state = hs_idle;
            end
         endcase
      end
   end
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '0;
         r.state <= hs_idle;
         r.scl_o <= 1'b1;
         r.sda_o <= 1'b1;
      end else begin
         r <= next_r;
      end
   end
   assign link.scl_o = r.scl_o;
   assign link.scl_oe = !r.scl_o;
   assign link.sda_host_o = r.sda_o;
   assign link.sda_host_oe = !r.sda_o;
   assign cmd_rdata = r.rd;
endmodule

// ---- verification/csb_link_assertions.sv ----
// Protocol checks on the two-wire link between host and device ends
`timescale 1ns/1ps
module csb_link_assertions (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_host_o,
   input wire logic sda_host_oe,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   chk_idle_after_rst: assert property ($past(sys_rst) |-> scl && sda)
      else $error("link not released after reset");
   chk_dev_moves_low: assert property ($changed(sda_dev_oe) |-> !scl)
      else $error("device moved data while clock high");
   chk_start_by_host: assert property (scl && $past(scl) && $fell(sda) |-> sda_host_oe)
      else $error("start not made by host");
   chk_scl_high_min: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
   chk_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
      else $error("clock low phase too short");
   chk_stop_release: assert property (scl && $past(scl) && $rose(sda) |-> !sda_dev_oe [*8])
      else $error("device drives right after stop");
   chk_dev_drive_bound: assert property ($rose(sda_dev_oe) |-> ##[1:450] !sda_dev_oe)
      else $error("device holds data line too long");
   chk_no_fight_high: assert property (scl && sda_dev_oe |-> !sda_host_oe)
      else $error("both ends drive data line");
   cov_stop: cover property (scl && $past(scl) && $rose(sda));
   cov_dev_ack: cover property ($rose(sda_dev_oe));
   cov_host_ack: cover property (scl && sda_host_oe && !sda_dev_oe);
endmodule

// ---- verification/clock_chip_smbus_byte_regs_tb.sv ----
// Self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
module clock_chip_smbus_byte_regs_tb;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [1:0] cmd_addr = 2'h0;
   logic [15:0] cmd_wdata = 16'h0000;
   logic cmd_write = 1'b0;
   logic cmd_read = 1'b0;
   logic [15:0] cmd_rdata;
   logic cpu_mode = 1'b0;
   logic power_down_n = 1'b1;
   logic [3:0] freq_select;
   logic spread_center, spread_enable, chipset_clock_run, cpu_clock_run;
   logic [1:0] spread_bandwidth;
   logic cpu_park_true_high, cpu_float;
   logic [7:0] freq_reg_view, cpu_reg_view;
   logic [31:0] mon_bits = 32'h0;
   int mon_n = 0;
   logic prev_scl = 1'b1;
   logic prev_sda = 1'b1;
   int num_errors = 0;
   int n_compared = 0;
   csb_link_if link();
   csb_device u_csb_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
      .freq_select_strap(4'ha), .cpu_interface_strap(cpu_mode),
      .current_multiplier_strap(1'b1), .power_down_n(power_down_n),
      .freq_select(freq_select), .spread_center(spread_center),
      .spread_enable(spread_enable), .spread_bandwidth(spread_bandwidth),
      .chipset_clock_run(chipset_clock_run), .cpu_clock_run(cpu_clock_run),
      .cpu_park_true_high(cpu_park_true_high), .cpu_float(cpu_float),
      .freq_reg_view(freq_reg_view), .cpu_reg_view(cpu_reg_view));
   csb_host u_csb_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_write(cmd_write),
      .cmd_read(cmd_read), .cmd_rdata(cmd_rdata));
   csb_link_assertions u_csb_link_assertions (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .scl_o(link.scl_o), .scl_oe(link.scl_oe), .sda_host_o(link.sda_host_o),
      .sda_host_oe(link.sda_host_oe), .sda_dev_o(link.sda_dev_o),
      .sda_dev_oe(link.sda_dev_oe), .scl(link.scl), .sda(link.sda));
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Bits since the last start, sampled mid-cycle so the link has settled
   always @(negedge clk_sys) begin
      prev_scl <= link.scl;
      prev_sda <= link.sda;
      if (prev_scl && link.scl && prev_sda && !link.sda) begin
         mon_n <= 0;
      end else if (!prev_scl && link.scl) begin
         mon_bits <= {mon_bits[30:0], link.sda};
         mon_n <= mon_n + 1;
      end
   end
   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_write <= 1'b1;
      @(posedge clk_sys);
      cmd_write <= 1'b0;
   endtask
   task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      cmd_addr <= a;
      cmd_read <= 1'b1;
      @(posedge clk_sys);
      cmd_read <= 1'b0;
      #1;
      d = cmd_rdata;
   endtask
   task automatic xfer(input logic rd, input logic [4:0] idx, input logic [7:0] wd,
         output logic [15:0] st);
      bus_wr(2'h1, {8'h00, wd});
      bus_wr(2'h0, {9'h000, 1'b1, rd, idx});
      for (int i = 0; i < 2000; i++) begin
         bus_rd(2'h0, st);
         if (st[9] === 1'b0) return;
      end
      num_errors++;
      close_out();
   endtask
   task automatic wr_reg(input logic [4:0] idx, input logic [7:0] d);
      logic [15:0] st;
      xfer(1'b0, idx, d, st);
      check(st[8], 1'b0);
      // The stop condition adds a last clock rise with the data line low
      check(mon_n, 28);
      check(mon_bits[27:0], {8'hd2, 1'b0, 3'h4, idx, 1'b0, d, 2'b00});
      bus_rd(2'h1, st);
      check(st, {8'h00, d});
   endtask
   task automatic rd_reg(input logic [4:0] idx, input logic [7:0] exp);
      logic [15:0] st;
      xfer(1'b1, idx, 8'h00, st);
      check(st[8:0], {1'b0, exp});
      check(mon_n, 19);
      check(mon_bits[18:0], {8'hd3, 1'b0, exp, 2'b00});
   endtask
   task automatic t_power_up();
      check(freq_reg_view, 8'h22);
      check(cpu_reg_view, 8'h7d);
      check(freq_select, 4'ha);
      check({spread_center, spread_enable, spread_bandwidth, chipset_clock_run,
         cpu_clock_run}, 6'h1f);
      rd_reg(5'h00, 8'h22);
      rd_reg(5'h01, 8'h7d);
   endtask
   task automatic t_override();
      wr_reg(5'h00, 8'hf7);
      check(freq_reg_view, 8'h22);
      wr_reg(5'h00, 8'h08);
      check(freq_reg_view, 8'h2a);
      wr_reg(5'h00, 8'hfe);
      check(freq_reg_view, 8'h7a);
      check(freq_select, 4'hf);
      rd_reg(5'h00, 8'h7a);
      wr_reg(5'h00, 8'h08);
      check(freq_select, 4'h0);
      wr_reg(5'h00, 8'h00);
      check(freq_reg_view, 8'h22);
   endtask
   task automatic t_cpu_reg();
      wr_reg(5'h01, 8'h82);
      check(cpu_reg_view, 8'h83);
      check({spread_center, spread_enable, spread_bandwidth, chipset_clock_run,
         cpu_clock_run}, 6'h20);
      @(posedge clk_sys);
      power_down_n <= 1'b0;
      // A whole read gives the power-down synchroniser (pd_s1, pd_s2) ample time to settle
      rd_reg(5'h01, 8'h83);
      check({cpu_park_true_high, cpu_float}, 2'b01);
      wr_reg(5'h01, 8'h7c);
      check({cpu_park_true_high, cpu_float}, 2'b10);
      @(posedge clk_sys);
      power_down_n <= 1'b1;
      rd_reg(5'h01, 8'h7d);
      check({cpu_park_true_high, cpu_float}, 2'b00);
   endtask
   task automatic t_unmapped();
      wr_reg(5'h05, 8'haa);
      rd_reg(5'h05, 8'h00);
      check(cpu_reg_view, 8'h7d);
   endtask
   task automatic t_open_drain();
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      cpu_mode <= 1'b1;
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      // Straps need three cycles through their synchroniser
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      check(freq_reg_view, 8'h23);
      check(cpu_reg_view, 8'h7d);
      wr_reg(5'h01, 8'h7e);
      @(posedge clk_sys);
      power_down_n <= 1'b0;
      rd_reg(5'h01, 8'h7f);
      check({cpu_park_true_high, cpu_float}, 2'b00);
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      t_power_up();
      t_override();
      t_cpu_reg();
      t_unmapped();
      t_open_drain();
      close_out();
   end
endmodule
